// ===== shared/tpmc_pkg.sv
// Overview of operation
// RL1 - write path select 1 loads compares via timer registers; software sets both update enables.
// RL2 - buffered write in pulse modes copies timer registers to compares on compare-0 match.
// RL3 - event select 00 gives no interrupt event, 01 gives compare-0 match.
// RL4 - event select 10 gives compare-5 match on channel 0, nothing on channel 1.
// RL5 - event select 11 gives counter overflow, but nothing in pulse-generator mode.
// RL6 - output 1 polarity bit 7: 0 rises on compare-3, falls on compare-4; 1 opposite.
// RL7 - output 0 polarity bit 6: 0 rises on compare-1, falls on compare-2; 1 opposite.
// RL8 - clear-on-match bit 4: 0 free-runs through compare-0 match, 1 clears counter.
// RL9 - in pulse modes counter always clears on compare-0 match, ignoring clear bit 0.
// RL10 - prescaler 0000 undivided, 1000..1011 divide by 2,4,8,16; other codes forbidden.
// RL11 - dma enable 1 issues a dma request on each compare-0 interrupt event.
// RL12 - unused bits of mode and dma registers read zero; fields reset to zero.
package tpmc_pkg;

  localparam int unsigned CNT_W = 16;
  localparam int unsigned N_CMP = 6;
  localparam int unsigned ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_DMA = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_STAGE = 8'h20;
  localparam logic [7:0] OFF_ACTIVE = 8'h40;

  // control register fields
  localparam int unsigned CTL_RUN_BIT = 0;
  localparam int unsigned CTL_MODE_LSB = 1;
  localparam int unsigned CTL_WPATH_BIT = 3;
  localparam int unsigned CTL_UPD0_BIT = 4;
  localparam int unsigned CTL_UPD1_BIT = 5;
  localparam int unsigned CTL_W = 6;

  // mode register fields
  localparam int unsigned MOD_POL1_BIT = 7;
  localparam int unsigned MOD_POL0_BIT = 6;
  localparam int unsigned MOD_CLR_BIT = 4;
  localparam int unsigned MOD_PSC_LSB = 0;
  localparam int unsigned MOD_ISEL_LSB = 8;
  localparam logic [31:0] MOD_MASK = 32'h0000_03df;

  localparam int unsigned DMA_ON_BIT = 0;
  localparam int unsigned STS_EVT_BIT = 0;
  localparam int unsigned STS_OVF_BIT = 1;
  localparam int unsigned STS_W = 2;

  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // prescaler codes
  localparam logic [3:0] PSC_DIV1 = 4'h0;
  localparam int unsigned PSC_DIV_BIT = 3;

  // interrupt event select codes
  localparam logic [1:0] ISEL_NONE = 2'h0;
  localparam logic [1:0] ISEL_CMP0 = 2'h1;
  localparam logic [1:0] ISEL_CMP5 = 2'h2;
  localparam logic [1:0] ISEL_OVF = 2'h3;

  typedef enum logic [1:0] {
    TPMC_TIMER,
    TPMC_PPG,
    TPMC_ILK_PPG,
    TPMC_RSVD
  } tpmc_mode_t;

endpackage : tpmc_pkg

// ===== shared/tpmc_tick_if.sv
`timescale 1ns/10ps
interface tpmc_tick_if;
  logic       run;
  logic [3:0] sel;
  logic       tick;
  modport pre  (input run, input sel, output tick);
  modport core (output run, output sel, input tick);
endinterface : tpmc_tick_if

// ===== core/tpmc_prescaler.sv
`timescale 1ns/10ps
module tpmc_prescaler
  import tpmc_pkg::*;
(
  input  wire logic   pclk,
  input  wire logic   presetn,
  tpmc_tick_if.pre    p
);

  logic [3:0] div_q;
  logic [3:0] div_d;
  logic       tick_q;
  logic       tick_d;

  // last count of a division period; undivided for 0000
  function automatic logic [3:0] tpmc_div_last(input logic [3:0] sel);
    logic [3:0] last;
    last = 4'h0;
    if (sel[PSC_DIV_BIT])
    begin
      last = 4'((5'h2 << sel[1:0]) - 5'h1);
    end
    return last;
  endfunction : tpmc_div_last

  always_comb
  begin
    div_d  = div_q;
    tick_d = 1'b0;
    if (!p.run)
    begin
      div_d = 4'h0;
    end
    else if (div_q >= tpmc_div_last(p.sel)) // RL10
    begin
      div_d  = 4'h0;
      tick_d = 1'b1;
    end
    else
    begin
      div_d = div_q + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q  <= 4'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  assign p.tick = tick_q;

endmodule : tpmc_prescaler

// ===== core/tpmc_top.sv
`timescale 1ns/10ps
module tpmc_top
  import tpmc_pkg::*;
#(
  parameter int unsigned CHANNEL = 0
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   pulse_output_zero,
  output logic                   pulse_output_one,
  output logic                   compare_zero_interrupt,
  output logic                   dma_req,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [31:0]       prdata_q, prdata_d;
  logic              pready_q, pready_d;
  logic              pslverr_q, pslverr_d;
  logic              wr_en;

  logic [CTL_W-1:0]  ctrl_q, ctrl_d;
  logic [31:0]       mode_q, mode_d;
  logic              dma_on_q, dma_on_d;
  logic [STS_W-1:0]  sts_q, sts_d;
  logic [STS_W-1:0]  mask_q, mask_d;
  logic [CNT_W-1:0]  stage_q [N_CMP];
  logic [CNT_W-1:0]  stage_d [N_CMP];
  logic [CNT_W-1:0]  cmp_q [N_CMP];
  logic [CNT_W-1:0]  cmp_d [N_CMP];

  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic              out0_q, out0_d;
  logic              out1_q, out1_d;
  logic              evt_q, evt_d;
  logic              dma_q, dma_d;
  logic              irq_q, irq_d;

  logic [N_CMP-1:0]  match;
  logic              ovf;
  logic              evt;
  logic              clr_on_match;
  logic              pulse_mode;
  logic              buffered;
  tpmc_mode_t        mode_sel;
  logic [1:0]        isel;

  tpmc_tick_if       tk ();

  // index of a compare slot at a window base, or N_CMP when outside it
  function automatic int unsigned tpmc_slot(input logic [7:0] a, input logic [7:0] base);
    int unsigned idx;
    idx = N_CMP;
    if (a >= base && a < base + 8'(4 * N_CMP) && a[1:0] == 2'b00)
    begin
      idx = int'(a - base) >> 2;
    end
    return idx;
  endfunction : tpmc_slot

  ////////////////////////////////////////////////////////////////////////////
  // decoded control

  assign mode_sel     = tpmc_mode_t'(ctrl_q[CTL_MODE_LSB +: 2]);
  assign pulse_mode   = (mode_sel == TPMC_PPG) || (mode_sel == TPMC_ILK_PPG);
  assign buffered     = ctrl_q[CTL_WPATH_BIT];
  assign isel         = mode_q[MOD_ISEL_LSB +: 2];
  assign clr_on_match = mode_q[MOD_CLR_BIT] || pulse_mode; // RL8 RL9

  assign tk.run = ctrl_q[CTL_RUN_BIT];
  assign tk.sel = mode_q[MOD_PSC_LSB +: 4];

  tpmc_prescaler u_psc (
    .pclk    (pclk),
    .presetn (presetn),
    .p       (tk.pre)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: no wait state, answer registered

  assign wr_en = psel && penable && pwrite && pready_q;

  always_comb
  begin
    int unsigned rs;
    int unsigned ra;
    rs        = tpmc_slot(paddr, OFF_STAGE);
    ra        = tpmc_slot(paddr, OFF_ACTIVE);
    prdata_d  = RST_ZERO;
    pslverr_d = 1'b0;
    pready_d  = psel && !penable && !pready_q;
    if (paddr == OFF_CTRL)
    begin
      prdata_d[CTL_W-1:0] = ctrl_q;
    end
    else if (paddr == OFF_MODE)
    begin
      prdata_d = mode_q & MOD_MASK; // RL12
    end
    else if (paddr == OFF_DMA)
    begin
      prdata_d[DMA_ON_BIT] = dma_on_q; // RL12
    end
    else if (paddr == OFF_COUNT)
    begin
      prdata_d[CNT_W-1:0] = cnt_q;
    end
    else if (paddr == OFF_STATUS)
    begin
      prdata_d[STS_W-1:0] = sts_q;
    end
    else if (paddr == OFF_MASK)
    begin
      prdata_d[STS_W-1:0] = mask_q;
    end
    else if (rs < N_CMP)
    begin
      prdata_d[CNT_W-1:0] = stage_q[rs];
    end
    else if (ra < N_CMP)
    begin
      prdata_d[CNT_W-1:0] = cmp_q[ra];
    end
    else
    begin
      pslverr_d = 1'b1;
    end
    if (!pready_d)
    begin
      prdata_d  = RST_ZERO;
      pslverr_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= RST_ZERO;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers and compare write path

  always_comb
  begin
    int unsigned ws;
    ws       = tpmc_slot(paddr, OFF_STAGE);
    ctrl_d   = ctrl_q;
    mode_d   = mode_q;
    dma_on_d = dma_on_q;
    mask_d   = mask_q;
    stage_d  = stage_q;
    cmp_d    = cmp_q;
    // buffered transfer on compare-0 match, independent of clear setting
    if (buffered && ctrl_q[CTL_UPD0_BIT] && ctrl_q[CTL_UPD1_BIT] && match[0]) // RL1 RL2
    begin
      cmp_d = stage_q;
    end
    if (wr_en)
    begin
      if (paddr == OFF_CTRL)
      begin
        ctrl_d = pwdata[CTL_W-1:0];
      end
      else if (paddr == OFF_MODE)
      begin
        mode_d = pwdata & MOD_MASK;
      end
      else if (paddr == OFF_DMA)
      begin
        dma_on_d = pwdata[DMA_ON_BIT];
      end
      else if (paddr == OFF_MASK)
      begin
        mask_d = pwdata[STS_W-1:0];
      end
      else if (ws < N_CMP)
      begin
        stage_d[ws] = pwdata[CNT_W-1:0];
        if (!buffered) // RL1
        begin
          cmp_d[ws] = pwdata[CNT_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q   <= '0; // RL12
      mode_q   <= RST_ZERO;
      dma_on_q <= 1'b0;
      mask_q   <= '0;
      stage_q  <= '{default: '0};
      cmp_q    <= '{default: '0};
    end
    else
    begin
      ctrl_q   <= ctrl_d;
      mode_q   <= mode_d;
      dma_on_q <= dma_on_d;
      mask_q   <= mask_d;
      stage_q  <= stage_d;
      cmp_q    <= cmp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // up-counter, matches and pulse outputs

  always_comb
  begin
    for (int m = 0; m < N_CMP; m++)
    begin
      match[m] = tk.tick && (cnt_q == cmp_q[m]);
    end
    ovf = tk.tick && (cnt_q == {CNT_W{1'b1}}) && !(match[0] && clr_on_match);
  end

  always_comb
  begin
    cnt_d  = cnt_q;
    out0_d = out0_q;
    out1_d = out1_q;
    if (tk.tick)
    begin
      if (match[0] && clr_on_match) // RL8 RL9
      begin
        cnt_d = '0;
      end
      else
      begin
        cnt_d = cnt_q + CNT_W'(1);
      end
    end
    if (pulse_mode)
    begin
      if (match[1])
      begin
        out0_d = !mode_q[MOD_POL0_BIT]; // RL7
      end
      else if (match[2])
      begin
        out0_d = mode_q[MOD_POL0_BIT]; // RL7
      end
      if (match[3])
      begin
        out1_d = !mode_q[MOD_POL1_BIT]; // RL6
      end
      else if (match[4])
      begin
        out1_d = mode_q[MOD_POL1_BIT]; // RL6
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q  <= '0;
      out0_q <= 1'b0;
      out1_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      out0_q <= out0_d;
      out1_q <= out1_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare interrupt event, dma request, sticky status

  always_comb
  begin
    case (isel)
      ISEL_NONE: evt = 1'b0; // RL3
      ISEL_CMP0: evt = match[0]; // RL3
      ISEL_CMP5: evt = (CHANNEL == 0) && match[5]; // RL4
      ISEL_OVF:  evt = ovf && (mode_sel != TPMC_PPG); // RL5
      default:   evt = 1'b0;
    endcase
  end

  always_comb
  begin
    evt_d = evt;
    dma_d = evt && dma_on_q; // RL11
    sts_d = sts_q;
    if (wr_en && paddr == OFF_STATUS)
    begin
      sts_d = sts_q & ~pwdata[STS_W-1:0];
    end
    // set wins over a clear in the same cycle
    if (evt)
    begin
      sts_d[STS_EVT_BIT] = 1'b1;
    end
    if (ovf)
    begin
      sts_d[STS_OVF_BIT] = 1'b1;
    end
    irq_d = |(sts_d & mask_d);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_q <= 1'b0;
      dma_q <= 1'b0;
      sts_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      evt_q <= evt_d;
      dma_q <= dma_d;
      sts_q <= sts_d;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign pulse_output_zero      = out0_q;
  assign pulse_output_one       = out1_q;
  assign compare_zero_interrupt = evt_q;
  assign dma_req                = dma_q;
  assign irq                    = irq_q;

endmodule : tpmc_top

// ===== tb/tpmc_properties.sv
`timescale 1ns/10ps
module tpmc_properties
  import tpmc_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              dma_req,
  input wire logic              compare_zero_interrupt
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence rd_s(a);
    pready && !pwrite && paddr == a;
  endsequence
  apb_answer_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  mode_zero_a: assert property (rd_s(OFF_MODE) |-> (prdata & ~MOD_MASK) == 32'h0)
    else $error("mode unused bits set");
  dma_zero_a: assert property (rd_s(OFF_DMA) |-> prdata[31:1] == 31'h0)
    else $error("dma unused bits set");
  dma_event_a: assert property (dma_req |-> compare_zero_interrupt)
    else $error("dma without event");
  unmapped_err_a: assert property (pready && paddr == 8'h18 |-> pslverr)
    else $error("no error on unmapped");
endmodule : tpmc_properties
////////////////////////////////////////
bind tpmc_top tpmc_properties u_tpmc_properties (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .dma_req, .compare_zero_interrupt);

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import tpmc_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, pulse_output_zero, pulse_output_one;
  logic        compare_zero_interrupt, dma_req, irq;
  int          errors, checked, cyc, nev, ndm, g, a, b;
  logic [7:0]  ra[3] = '{OFF_MODE, OFF_DMA, OFF_MASK};
  logic [31:0] rw[3] = '{32'hffff_ffdb, 32'hffff_ffe1, 32'h3};
  logic [31:0] re[3] = '{32'h3db, 32'h1, 32'h3};
  logic [3:0]  pc[5] = '{4'h0, 4'h8, 4'h9, 4'ha, 4'hb};
  tpmc_top u_tpmc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pulse_output_zero, .pulse_output_one,
    .compare_zero_interrupt, .dma_req, .irq);
  initial
  begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  always @(negedge pclk)
  begin
    nev += compare_zero_interrupt;
    ndm += dma_req;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 95000)
    begin
      errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////
  task complete_run();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task chk(input string n, input logic [31:0] e, input logic [31:0] v);
    checked++;
    if (v !== e)
    begin
      errors++;
      $display("[FAIL] %s exp %h got %h", n, e, v);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // request stands until pready is seen high at a rising edge
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task rchk(input logic [7:0] ad, input logic [31:0] e);
    apb(0, ad, 0);
    chk("read", e, rd);
  endtask : rchk
  task wait_ev();
    g = 0;
    do
    begin
      @(posedge pclk);
      #1;
      g++;
    end while (compare_zero_interrupt !== 1'b1 && g < 70000);
  endtask : wait_ev
  task hi(input int n);
    a = 0;
    b = 0;
    repeat (n)
    begin
      @(posedge pclk);
      #1;
      a += pulse_output_zero;
      b += pulse_output_one;
    end
  endtask : hi
  ////////////////////////////////////////
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    rchk(OFF_MODE, 0);
    rchk(OFF_DMA, 0);
    for (int i = 0; i < 3; i++)
    begin
      apb(1, ra[i], rw[i]);
      rchk(ra[i], re[i]);
    end
    apb(0, 8'h18, 0);
    chk("slverr", 1, er);
    apb(1, OFF_STAGE, 3);
    apb(1, 8'h34, 2);
    apb(1, OFF_CTRL, 1);
    for (int i = 0; i < 5; i++)
    begin
      apb(1, OFF_MODE, {20'h0, 12'h110} | pc[i]);
      repeat (3) wait_ev();
      chk("gap", 4 << i, g);
    end
    chk("dma", nev, ndm);
    apb(1, OFF_DMA, 0);
    // let a request launched at the write edge be counted first
    @(posedge pclk);
    a = ndm;
    apb(1, OFF_MODE, 32'h210);
    repeat (2) wait_ev();
    chk("cmp5", 4, g);
    chk("dmaoff", a, ndm);
    // compare-5 event leaves the counter one step before its clear
    rchk(OFF_COUNT, 0);
    apb(1, OFF_MODE, 32'h10);
    @(posedge pclk);
    a = nev;
    repeat (40) @(posedge pclk);
    chk("none", a, nev);
    // pulse-generator mode entered while the counter is still below compare 0
    apb(1, OFF_CTRL, 3);
    for (int i = 0; i < 5; i++)
      apb(1, OFF_STAGE + 8'(4 * i), (i == 0) ? 7 : (i == 1) ? 2 : (i == 2) ? 5 : (i == 3) ? 1 : 6);
    for (int p = 0; p < 2; p++)
    begin
      apb(1, OFF_MODE, p ? 32'hc0 : 32'h0);
      repeat (16) @(posedge pclk);
      hi(64);
      chk("out0", p ? 40 : 24, a);
      chk("out1", p ? 24 : 40, b);
    end
    apb(1, OFF_CTRL, 32'h3a);
    apb(1, 8'h24, 3);
    rchk(8'h44, 2);
    apb(1, OFF_CTRL, 32'h3b);
    repeat (20) @(posedge pclk);
    rchk(8'h44, 3);
    // free-running timer mode up to overflow
    apb(1, OFF_CTRL, 1);
    apb(1, OFF_MODE, 32'h300);
    wait_ev();
    chk("ovf", 1, g < 70000);
    apb(1, OFF_MODE, 0);
    #1 chk("irq", 1, irq);
    apb(1, OFF_MASK, 0);
    #1 chk("irq", 0, irq);
    apb(1, OFF_MASK, 3);
    apb(1, OFF_STATUS, 3);
    #1 chk("irq", 0, irq);
    // reset in mid-run
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rchk(OFF_CTRL, 0);
    rchk(OFF_MODE, 0);
    complete_run();
  end
endmodule : tb_top
